//--- hdl/tsrb_pkg.sv
/*
 package for the trigger sequencer with reading buffer: sizes, limits,
 timing constants, enumerations and config/command structs.
 assumes a single 200 MHz instrument clock.
*/
package tsrb_pkg;
    localparam int TSRB_CLK_HZ = 200_000_000;
    localparam int TSRB_DEPTH = 1024;
    localparam int TSRB_AW = 10;
    localparam int TSRB_RW = 24;
    localparam logic [10:0] TSRB_PTS_MIN = 11'h002;
    localparam logic [10:0] TSRB_PTS_MAX = 11'h400;
    localparam logic [13:0] TSRB_MCNT_MIN = 14'h0001;
    localparam logic [13:0] TSRB_MCNT_MAX = 14'h270f;
    localparam logic [10:0] TSRB_SCNT_MIN = 11'h001;
    localparam logic [10:0] TSRB_SCNT_MAX = 11'h400;
    // delays and intervals are given in milliseconds (0.001 s resolution)
    localparam int TSRB_MS_NS = 1_000_000;
    localparam int TSRB_CLK_NS = 5;
    localparam logic [17:0] TSRB_CYC_PER_MS = 18'(TSRB_MS_NS / TSRB_CLK_NS);
    localparam logic [29:0] TSRB_TIME_MAX_MS = 30'h3b9ac9ff;
    localparam logic [29:0] TSRB_TIMER_MIN_MS = 30'h0000001;

    typedef enum logic [2:0] {
        TSRB_SRC_IMM, TSRB_SRC_EXT, TSRB_SRC_TIM, TSRB_SRC_MAN, TSRB_SRC_BUS
    } tsrb_src_t;
    typedef enum logic [1:0] {TSRB_FEED_RAW, TSRB_FEED_MATH, TSRB_FEED_NONE} tsrb_feed_t;
    typedef enum logic {TSRB_CTL_STORAGE_DISABLED_CONTROL, TSRB_CTL_NEXT} tsrb_ctl_t;

    typedef struct packed {
        logic [13:0] meas_count;
        logic meas_inf;
        logic [10:0] samp_count;
        logic [29:0] delay_ms;
        logic auto_delay;
        logic [29:0] timer_ms;
        tsrb_src_t source;
        logic cont_init;
        tsrb_feed_t feed;
        tsrb_ctl_t ctl;
        logic [10:0] points;
    } tsrb_cfg_t;

    typedef struct packed {
        logic initiate;
        logic abort;
        logic bypass;
        logic clear;
        logic dump;
        logic single_read;
        logic ext_front_panel_event_key;
        logic front_panel_event_key;
        logic bus_front_panel_event_key;
    } tsrb_cmd_t;
endpackage : tsrb_pkg

//--- hdl/tsrb_ms_timer.sv
/*
 millisecond down-counter: loads a count of milliseconds and pulses done
 when it has elapsed. assumes a 200 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tsrb_ms_timer
    import tsrb_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic load_in,
    input wire logic [29:0] ms_in,
    output logic busy_out,
    output logic done_out
);
    logic [17:0] cyc_r, cyc_nxt;
    logic [29:0] ms_r, ms_nxt;
    logic busy_r, busy_nxt, done_r, done_nxt;

    always_comb begin
        cyc_nxt = cyc_r;
        ms_nxt = ms_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (load_in) begin
            cyc_nxt = TSRB_CYC_PER_MS - 18'h1;
            ms_nxt = ms_in;
            busy_nxt = (ms_in != 30'h0);
            done_nxt = (ms_in == 30'h0);
        end else if (busy_r) begin
            if (cyc_r != 18'h0) begin
                cyc_nxt = cyc_r - 18'h1;
            end else if (ms_r == 30'h1) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                ms_nxt = ms_r - 30'h1;
                cyc_nxt = TSRB_CYC_PER_MS - 18'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            cyc_r <= 18'h0;
            ms_r <= 30'h0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cyc_r <= cyc_nxt;
            ms_r <= ms_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy_out = busy_r;
    assign done_out = done_r;
endmodule : tsrb_ms_timer
`default_nettype wire

//--- hdl/tsrb_top.sv
/*
 trigger sequencer with reading buffer: idle/initiate/abort sequencer,
 measure and sample loops, event source gating, delay, and a reading
 store with read-out. assumes host commands arrive as one-cycle pulses
 and the measurement engine answers each device action with a reading.
*/
// How it works
// RULE1: clear empties buffer; stores overwrite from start, old data may remain
// RULE2: buffer depth 2..1024 accepted and reported back
// RULE3: feed picks raw, math or nothing; nothing writes no reading
// RULE4: storage control storage_disabled_control stores nothing
// RULE5: control next stores until programmed depth, then stops
// RULE6: read-out request streams every held reading to the host
// RULE7: one-shot initiate leaves idle; returns idle unless continuous
// RULE8: continuous initiation restarts from sequence top instead of idling
// RULE9: continuous mode refuses sample count above one and single read
// RULE10: abort returns to top; idle unless continuous
// RULE11: abort resets scan channel pointer to first channel
// RULE12: measure count 1..9999 or infinite, default 1, limits readable
// RULE13: loop until measure count done, waiting for event each pass
// RULE14: after event wait programmed delay 0..999999.999 s
// RULE15: auto-delay off inserts no delay
// RULE16: immediate source passes event stage at once
// RULE17: external source waits for external trigger input
// RULE18: timer source: first pass immediate, later on each expiry
// RULE19: manual source uses panel key; bus source uses bus trigger
// RULE20: bypass releases only while waiting, else error flagged and ignored
// RULE21: sample count 1..1024 sets device actions per loop
// RULE22: single read refused when sample count above one and buffer holds data
// RULE23: sample loop nested within each measure pass
`timescale 1ns/10ps
`default_nettype none
module tsrb_top
    import tsrb_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire tsrb_cfg_t cfg_in,
    input wire tsrb_cmd_t cmd_in,
    input wire logic [TSRB_RW-1:0] raw_reading_in,
    input wire logic [TSRB_RW-1:0] math_reading_feed_in,
    input wire logic reading_valid_in,
    input wire logic host_ready_in,
    output logic action_out,
    output logic idle_out,
    output logic waiting_event_out,
    output logic scan_reset_out,
    output logic cfg_error_out,
    output logic cmd_error_out,
    output logic [10:0] points_out,
    output logic [13:0] meas_max_out,
    output logic [13:0] meas_min_out,
    output logic [10:0] stored_out,
    output logic [TSRB_RW-1:0] dump_data_out,
    output logic dump_valid_out,
    output logic dump_last_out
);
    typedef enum logic [2:0] {
        TSRB_ST_IDLE, TSRB_ST_EVENT, TSRB_ST_DELAY, TSRB_ST_ACT, TSRB_ST_WAITRD
    } tsrb_state_t;

    function automatic logic cfg_ok(input tsrb_cfg_t c);
        cfg_ok = (c.points >= TSRB_PTS_MIN) && (c.points <= TSRB_PTS_MAX)
              && (c.samp_count >= TSRB_SCNT_MIN) && (c.samp_count <= TSRB_SCNT_MAX)
              && (c.meas_inf || ((c.meas_count >= TSRB_MCNT_MIN)
                                 && (c.meas_count <= TSRB_MCNT_MAX)))
              && (c.delay_ms <= TSRB_TIME_MAX_MS)
              && (c.timer_ms >= TSRB_TIMER_MIN_MS) && (c.timer_ms <= TSRB_TIME_MAX_MS)
              && !(c.cont_init && (c.samp_count > TSRB_SCNT_MIN));
    endfunction : cfg_ok

    // ------------------------------------------------------------
    // configuration shadow
    // ------------------------------------------------------------
    tsrb_cfg_t cfg_r, cfg_nxt;
    logic cfg_err_r, cfg_err_nxt;
    localparam tsrb_cfg_t TSRB_CFG_RST = '{meas_count: TSRB_MCNT_MIN, meas_inf: 1'b0,
        samp_count: TSRB_SCNT_MIN, delay_ms: 30'h0, auto_delay: 1'b1,
        timer_ms: TSRB_TIMER_MIN_MS, source: TSRB_SRC_IMM, cont_init: 1'b0,
        feed: TSRB_FEED_RAW, ctl: TSRB_CTL_STORAGE_DISABLED_CONTROL, points: TSRB_PTS_MIN};

    // RULE2 RULE9 RULE12 RULE21: range checks, refused settings keep old value
    always_comb begin
        cfg_nxt = cfg_r;
        cfg_err_nxt = 1'b0;
        if (cfg_in != cfg_r) begin
            if (cfg_ok(cfg_in)) begin
                cfg_nxt = cfg_in;
            end else begin
                cfg_err_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            cfg_r <= TSRB_CFG_RST;
            cfg_err_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            cfg_err_r <= cfg_err_nxt;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    tsrb_state_t st_r, st_nxt;
    logic [13:0] mdone_r, mdone_nxt;
    logic [10:0] sdone_r, sdone_nxt;
    logic first_r, first_nxt;
    logic cerr_r, cerr_nxt;
    logic tim_load, tim_busy;
    logic dly_load, dly_done;
    logic [29:0] dly_ms;
    logic event_hit;
    logic bypass_ok;
    logic have_data;

    // RULE16 RULE17 RULE19: source selection
    always_comb begin
        case (cfg_r.source)
            TSRB_SRC_IMM: event_hit = 1'b1;
            TSRB_SRC_EXT: event_hit = cmd_in.ext_front_panel_event_key;
            // RULE18: first pass at once; busy low keeps an expiry that lands mid-action
            TSRB_SRC_TIM: event_hit = first_r || !tim_busy;
            TSRB_SRC_MAN: event_hit = cmd_in.front_panel_event_key;
            TSRB_SRC_BUS: event_hit = cmd_in.bus_front_panel_event_key;
            default: event_hit = 1'b0;
        endcase
    end

    assign bypass_ok = cmd_in.bypass && (st_r == TSRB_ST_EVENT);
    // RULE15: auto-delay off loads zero
    assign dly_ms = cfg_r.auto_delay ? cfg_r.delay_ms : 30'h0;

    always_comb begin
        st_nxt = st_r;
        mdone_nxt = mdone_r;
        sdone_nxt = sdone_r;
        first_nxt = first_r;
        cerr_nxt = 1'b0;
        tim_load = 1'b0;
        dly_load = 1'b0;
        // RULE20: bypass outside the event wait is an error
        if (cmd_in.bypass && !bypass_ok) begin
            cerr_nxt = 1'b1;
        end
        // RULE9 RULE22: single read refusal
        if (cmd_in.single_read && (cfg_r.cont_init
                || ((cfg_r.samp_count > TSRB_SCNT_MIN) && have_data))) begin
            cerr_nxt = 1'b1;
        end
        case (st_r)
            TSRB_ST_IDLE: begin
                // RULE7 RULE8: leave idle on initiate or continuous
                if (cmd_in.initiate || cfg_r.cont_init) begin
                    st_nxt = TSRB_ST_EVENT;
                    mdone_nxt = 14'h0;
                    first_nxt = 1'b1;
                end
            end
            TSRB_ST_EVENT: begin
                if (event_hit || bypass_ok) begin
                    // RULE18: timer restarts on each pass it serves
                    tim_load = (cfg_r.source == TSRB_SRC_TIM);
                    first_nxt = 1'b0;
                    // RULE14: start programmed delay
                    dly_load = 1'b1;
                    sdone_nxt = 11'h0;
                    st_nxt = TSRB_ST_DELAY;
                end
            end
            TSRB_ST_DELAY: begin
                if (dly_done) begin
                    st_nxt = TSRB_ST_ACT;
                end
            end
            TSRB_ST_ACT: begin
                st_nxt = TSRB_ST_WAITRD;
            end
            TSRB_ST_WAITRD: begin
                if (reading_valid_in) begin
                    // RULE23: samples nested in one measure pass
                    if (sdone_r + 11'h1 < cfg_r.samp_count) begin
                        sdone_nxt = sdone_r + 11'h1;
                        st_nxt = TSRB_ST_ACT;
                    // RULE13: count passes until measure count done
                    end else if (cfg_r.meas_inf || (mdone_r + 14'h1 < cfg_r.meas_count)) begin
                        mdone_nxt = cfg_r.meas_inf ? mdone_r : mdone_r + 14'h1;
                        st_nxt = TSRB_ST_EVENT;
                    end else begin
                        // RULE7 RULE8: back to top, idle unless continuous
                        mdone_nxt = 14'h0;
                        first_nxt = 1'b1;
                        st_nxt = cfg_r.cont_init ? TSRB_ST_EVENT : TSRB_ST_IDLE;
                    end
                end
            end
            default: st_nxt = TSRB_ST_IDLE;
        endcase
        // RULE10: abort returns to the top
        if (cmd_in.abort) begin
            mdone_nxt = 14'h0;
            first_nxt = 1'b1;
            st_nxt = cfg_r.cont_init ? TSRB_ST_EVENT : TSRB_ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            st_r <= TSRB_ST_IDLE;
            mdone_r <= 14'h0;
            sdone_r <= 11'h0;
            first_r <= 1'b1;
            cerr_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            mdone_r <= mdone_nxt;
            sdone_r <= sdone_nxt;
            first_r <= first_nxt;
            cerr_r <= cerr_nxt;
        end
    end

    tsrb_ms_timer u_interval (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .load_in(tim_load),
        .ms_in(cfg_r.timer_ms),
        .busy_out(tim_busy),
        .done_out()
    );

    tsrb_ms_timer u_delay (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .load_in(dly_load),
        .ms_in(dly_ms),
        .busy_out(),
        .done_out(dly_done)
    );

    // ------------------------------------------------------------
    // reading store
    // ------------------------------------------------------------
    logic [TSRB_RW-1:0] mem_r [TSRB_DEPTH];
    logic [TSRB_RW-1:0] wdata;
    logic [10:0] wptr_r, wptr_nxt, cnt_r, cnt_nxt, rptr_r, rptr_nxt;
    logic storing_r, storing_nxt, dumping_r, dumping_nxt;
    logic [TSRB_RW-1:0] dd_r, dd_nxt;
    logic dv_r, dv_nxt, dl_r, dl_nxt;
    logic wr_en;

    assign have_data = (cnt_r != 11'h0);
    // RULE3: feed selects stored value
    assign wdata = (cfg_r.feed == TSRB_FEED_MATH) ? math_reading_feed_in : raw_reading_in;
    // RULE3 RULE4 RULE5: write only while storing with a real feed
    assign wr_en = storing_r && reading_valid_in && (st_r == TSRB_ST_WAITRD)
                   && (cfg_r.feed != TSRB_FEED_NONE) && (cfg_r.ctl == TSRB_CTL_NEXT);

    always_comb begin
        wptr_nxt = wptr_r;
        cnt_nxt = cnt_r;
        storing_nxt = storing_r;
        rptr_nxt = rptr_r;
        dumping_nxt = dumping_r;
        dd_nxt = dd_r;
        dv_nxt = dv_r && !host_ready_in;
        dl_nxt = dl_r;
        // RULE1: a new store starts at entry zero
        if ((st_r == TSRB_ST_IDLE) && (st_nxt != TSRB_ST_IDLE)) begin
            storing_nxt = (cfg_r.ctl == TSRB_CTL_NEXT);
            wptr_nxt = 11'h0;
        end
        if (wr_en) begin
            wptr_nxt = wptr_r + 11'h1;
            if (wptr_r >= cnt_r) begin
                cnt_nxt = wptr_r + 11'h1;
            end
            // RULE5: stop once programmed depth is reached
            if (wptr_r + 11'h1 >= cfg_r.points) begin
                storing_nxt = 1'b0;
            end
        end
        // RULE6: stream out all held readings
        if (cmd_in.dump && !dumping_r && have_data) begin
            dumping_nxt = 1'b1;
            rptr_nxt = 11'h0;
        end
        if (dumping_r && (!dv_r || host_ready_in)) begin
            dd_nxt = mem_r[rptr_r[TSRB_AW-1:0]];
            dv_nxt = 1'b1;
            dl_nxt = (rptr_r + 11'h1 == cnt_r);
            rptr_nxt = rptr_r + 11'h1;
            dumping_nxt = !(rptr_r + 11'h1 == cnt_r);
        end
        // RULE1: clear empties the buffer
        if (cmd_in.clear) begin
            cnt_nxt = 11'h0;
            wptr_nxt = 11'h0;
            dumping_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (wr_en) begin
            mem_r[wptr_r[TSRB_AW-1:0]] <= wdata;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            wptr_r <= 11'h0;
            cnt_r <= 11'h0;
            rptr_r <= 11'h0;
            storing_r <= 1'b0;
            dumping_r <= 1'b0;
            dd_r <= '0;
            dv_r <= 1'b0;
            dl_r <= 1'b0;
        end else begin
            wptr_r <= wptr_nxt;
            cnt_r <= cnt_nxt;
            rptr_r <= rptr_nxt;
            storing_r <= storing_nxt;
            dumping_r <= dumping_nxt;
            dd_r <= dd_nxt;
            dv_r <= dv_nxt;
            dl_r <= dl_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign action_out = (st_r == TSRB_ST_ACT);
    assign idle_out = (st_r == TSRB_ST_IDLE);
    assign waiting_event_out = (st_r == TSRB_ST_EVENT);
    // RULE11: scan pointer back to first channel on abort
    assign scan_reset_out = cmd_in.abort;
    assign cfg_error_out = cfg_err_r;
    assign cmd_error_out = cerr_r;
    assign points_out = cfg_r.points;
    assign meas_max_out = TSRB_MCNT_MAX;
    assign meas_min_out = TSRB_MCNT_MIN;
    assign stored_out = cnt_r;
    assign dump_data_out = dd_r;
    assign dump_valid_out = dv_r;
    assign dump_last_out = dl_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_action_done;
        (st_r == TSRB_ST_WAITRD) && reading_valid_in;
    endsequence

    chk_abort_idle: assert property (cmd_in.abort && !cfg_r.cont_init |=> idle_out) // RULE10
        else $error("abort did not idle");
    chk_abort_cont: assert property (cmd_in.abort && cfg_r.cont_init |=> waiting_event_out) // RULE10
        else $error("abort did not restart");
    chk_init_leave: assert property (idle_out && cmd_in.initiate && !cmd_in.abort
        |=> waiting_event_out) // RULE7
        else $error("initiate ignored");
    chk_imm_pass: assert property (waiting_event_out && cfg_r.source == TSRB_SRC_IMM
        && !cmd_in.abort |=> st_r == TSRB_ST_DELAY) // RULE16
        else $error("immediate source waited");
    chk_ext_hold: assert property (waiting_event_out && cfg_r.source == TSRB_SRC_EXT
        && !cmd_in.ext_front_panel_event_key && !cmd_in.bypass && !cmd_in.abort |=> waiting_event_out) // RULE17
        else $error("external wait left early");
    chk_bypass_err: assert property (cmd_in.bypass && !waiting_event_out |=> cmd_error_out) // RULE20
        else $error("stray bypass not flagged");
    chk_none_write: assert property (cfg_r.feed == TSRB_FEED_NONE |-> !wr_en) // RULE3
        else $error("write with no feed");
    chk_storage_disabled_control_store: assert property (cfg_r.ctl == TSRB_CTL_STORAGE_DISABLED_CONTROL && !cmd_in.clear
        |=> $stable(cnt_r)) // RULE4
        else $error("store while disabled");
    chk_depth_cap: assert property (cnt_r <= cfg_r.points || $changed(cfg_r.points)) // RULE5
        else $error("store passed depth");
    chk_clear_empty: assert property (cmd_in.clear |=> stored_out == 11'h0) // RULE1
        else $error("clear left data");
    chk_sample_nest: assert property (s_action_done ##0 (sdone_r + 11'h1 < cfg_r.samp_count)
        && !cmd_in.abort |=> action_out) // RULE23
        else $error("sample loop broken");
endmodule : tsrb_top
`default_nettype wire

//--- bench/tsrb_partner.sv
/*
 bench model of the far side: a measurement engine that answers each
 device action with one reading, and a host that stalls dump words.
 assumes the bench seeds $urandom once before traffic starts.
*/
`timescale 1ns/10ps
`default_nettype none
module tsrb_partner
    import tsrb_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic action_in,
    output logic [TSRB_RW-1:0] raw_out = '0,
    output logic [TSRB_RW-1:0] math_out = '0,
    output logic valid_out = 1'b0,
    output logic host_ready_out = 1'b0
);
    // ----------------------------------------
    // engine answer, prompt or slow
    // ----------------------------------------
    logic [TSRB_RW-1:0] seq_r = '0;
    int due = 0;

    always @(posedge sys_clk_in) begin
        if (action_in === 1'b1)
            due = 1 + $urandom % 6;
    end

    always @(negedge sys_clk_in) begin
        host_ready_out <= ($urandom % 4) != 0;
        // idle lines flip so a stale word storage_disabled_control passes for a reading
        valid_out <= (due == 1);
        raw_out <= (due == 1) ? 24'h0a0000 + seq_r : ~raw_out;
        math_out <= (due == 1) ? 24'h050000 + seq_r : ~math_out;
        seq_r <= seq_r + 24'(due == 1);
        if (due > 0)
            due--;
    end
endmodule : tsrb_partner
`default_nettype wire

//--- bench/tsrb_tb_top.sv
/*
 self-checking bench for the trigger sequencer with reading buffer.
 assumes the partner model answers device actions and stalls the host.
*/
`timescale 1ns/10ps
`default_nettype none
module tsrb_tb_top
    import tsrb_pkg::*;
;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    localparam tsrb_cmd_t C_INIT = '{initiate: 1'b1, default: 1'b0};
    localparam tsrb_cmd_t C_ABT = '{abort: 1'b1, default: 1'b0};
    localparam tsrb_cmd_t C_BYP = '{bypass: 1'b1, default: 1'b0};
    localparam tsrb_cmd_t C_CLR = '{clear: 1'b1, default: 1'b0};
    localparam tsrb_cmd_t C_DMP = '{dump: 1'b1, default: 1'b0};
    localparam tsrb_cmd_t C_SRD = '{single_read: 1'b1, default: 1'b0};
    localparam tsrb_cmd_t C_EXT = '{ext_front_panel_event_key: 1'b1, default: 1'b0};
    localparam tsrb_cmd_t C_KEY = '{front_panel_event_key: 1'b1, default: 1'b0};
    localparam tsrb_cmd_t C_BUS = '{bus_front_panel_event_key: 1'b1, default: 1'b0};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    tsrb_cfg_t cfg = '{meas_count: 14'h0001, samp_count: 11'h001, timer_ms: 30'h0000001,
                       points: 11'h002, source: TSRB_SRC_IMM, feed: TSRB_FEED_RAW,
                       ctl: TSRB_CTL_NEXT, default: '0};
    tsrb_cfg_t t;
    tsrb_cmd_t cmd = '0;
    logic [TSRB_RW-1:0] rr, mr, dd;
    logic rv, hr, act, idl, wev, srst, cfe, cme, dv, dl;
    logic [10:0] pts_o, sto;
    logic [13:0] mx, mn;
    logic [TSRB_RW-1:0] mem [0:1023];
    int fails = 0;
    int cmp_count = 0;
    int acts = 0;
    int wp = 0;
    int cur_pts = 0;
    int exp_sto = 0;
    bit wr_on = 1'b0;

    always #2.5 clk = ~clk;

    tsrb_top i_dut (.sys_clk_in(clk), .rstn_in(rstn), .cfg_in(cfg), .cmd_in(cmd),
        .raw_reading_in(rr), .math_reading_feed_in(mr), .reading_valid_in(rv),
        .host_ready_in(hr), .action_out(act), .idle_out(idl), .waiting_event_out(wev),
        .scan_reset_out(srst), .cfg_error_out(cfe), .cmd_error_out(cme), .points_out(pts_o),
        .meas_max_out(mx), .meas_min_out(mn), .stored_out(sto), .dump_data_out(dd),
        .dump_valid_out(dv), .dump_last_out(dl));
    tsrb_partner i_eng (.sys_clk_in(clk), .action_in(act), .raw_out(rr), .math_out(mr),
        .valid_out(rv), .host_ready_out(hr));

    // expected buffer image: stores overwrite from entry 0 each run
    always @(posedge clk) begin
        if (act === 1'b1)
            acts++;
        if (rv === 1'b1 && wr_on && wp < cur_pts) begin
            mem[wp] = (cfg.feed == TSRB_FEED_MATH) ? mr : rr;
            wp++;
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic stop_test();
        if (fails == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task automatic chk(input logic ok, input string what);
        cmp_count++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask : chk

    task automatic send(input tsrb_cmd_t c);
        @(negedge clk);
        cmd = c;
        @(negedge clk);
        cmd = '0;
    endtask : send

    task automatic wait_idle();
        int n;
        n = 0;
        repeat (3) @(negedge clk);
        while (idl !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        chk(idl === 1'b1, "no return to idle");
    endtask : wait_idle

    task automatic dump_check(input int n);
        int k;
        int w;
        k = 0;
        w = 0;
        send(C_DMP);
        while (k < n && w < 5000) begin
            @(posedge clk);
            if (dv === 1'b1 && hr === 1'b1) begin
                chk(dd === mem[k], "dump word");
                chk(dl === (k == n - 1), "dump last flag");
                k++;
            end
            w++;
        end
        chk(k == n, "dump short");
    endtask : dump_check

    task automatic run_case(input int pts, input int mc, input int sc, input tsrb_feed_t fd,
                            input tsrb_ctl_t ct, input bit clr);
        int n;
        n = (fd == TSRB_FEED_NONE || ct == TSRB_CTL_STORAGE_DISABLED_CONTROL) ? 0 : (mc * sc < pts ? mc * sc : pts);
        @(negedge clk);
        cfg.points = 11'(pts);
        cfg.meas_count = 14'(mc);
        cfg.samp_count = 11'(sc);
        cfg.feed = fd;
        cfg.ctl = ct;
        cfg.auto_delay = 1'($urandom % 2);
        if (clr)
            send(C_CLR);
        if (clr)
            exp_sto = 0;
        wr_on = n > 0;
        cur_pts = pts;
        wp = 0;
        acts = 0;
        send(C_INIT);
        wait_idle();
        chk(pts_o === 11'(pts), "depth readback");
        chk(acts == mc * sc, "action count");
        if (n > exp_sto)
            exp_sto = n;
        chk(sto === 11'(exp_sto), "stored count");
        if (exp_sto > 0)
            dump_check(exp_sto);
        if (sc > 1 && exp_sto > 0) begin
            send(C_SRD);
            chk(cme === 1'b1, "single read accepted");
        end
    endtask : run_case

    task automatic bad_cfg(input tsrb_cfg_t c);
        tsrb_cfg_t keep;
        keep = cfg;
        @(negedge clk);
        cfg = c;
        @(negedge clk);
        chk(cfe === 1'b1 && pts_o === keep.points, "bad config taken");
        cfg = keep;
    endtask : bad_cfg

    task automatic ev_case(input tsrb_src_t src, input tsrb_cmd_t ev);
        @(negedge clk);
        cfg.source = src;
        cfg.meas_count = 14'h0002;
        cfg.samp_count = 11'h001;
        cfg.ctl = TSRB_CTL_STORAGE_DISABLED_CONTROL;
        acts = 0;
        send(C_INIT);
        repeat (20) @(negedge clk);
        chk(wev === 1'b1 && acts == 0, "passed without event");
        send(ev);
        repeat (16) @(negedge clk);
        chk(wev === 1'b1 && acts == 1, "event not taken");
        send(C_BYP);
        wait_idle();
        chk(acts == 2, "bypass not taken");
    endtask : ev_case

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        #500000;
        fails++;
        stop_test();
    end

    initial begin
        void'($urandom(32'he601));
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        chk(idl === 1'b1 && pts_o === 11'h002, "reset state");
        chk(mx === 14'h270f && mn === 14'h0001, "count limits");
        t = cfg;
        t.points = 11'h401;
        bad_cfg(t);
        t = cfg;
        t.meas_count = 14'h2710;
        bad_cfg(t);
        run_case(8, 5, 1, TSRB_FEED_RAW, TSRB_CTL_NEXT, 1'b1);
        run_case(8, 2, 1, TSRB_FEED_MATH, TSRB_CTL_NEXT, 1'b0);
        run_case(3, 2, 3, TSRB_FEED_RAW, TSRB_CTL_NEXT, 1'b1);
        run_case(4, 3, 1, TSRB_FEED_NONE, TSRB_CTL_NEXT, 1'b1);
        run_case(4, 3, 1, TSRB_FEED_RAW, TSRB_CTL_STORAGE_DISABLED_CONTROL, 1'b1);
        repeat (6) begin
            run_case(2 + $urandom % 7, 1 + $urandom % 4, 1 + $urandom % 3,
                     tsrb_feed_t'($urandom % 3), tsrb_ctl_t'($urandom % 2), 1'b1);
        end
        ev_case(TSRB_SRC_EXT, C_EXT);
        ev_case(TSRB_SRC_MAN, C_KEY);
        ev_case(TSRB_SRC_BUS, C_BUS);
        acts = 0;
        cfg.source = TSRB_SRC_TIM;
        send(C_INIT);
        repeat (20) @(negedge clk);
        chk(acts == 1 && wev === 1'b1, "timer wait");
        cfg.source = TSRB_SRC_BUS;
        cmd = C_ABT;
        #1 chk(srst === 1'b1, "scan pointer not reset");
        @(negedge clk);
        cmd = '0;
        chk(idl === 1'b1, "abort left sequencer busy");
        send(C_BYP);
        chk(cme === 1'b1, "stray bypass accepted");
        @(negedge clk);
        cfg.meas_count = 14'h0001;
        cfg.cont_init = 1'b1;
        acts = 0;
        repeat (10) @(negedge clk);
        chk(idl === 1'b0, "continuous stayed idle");
        send(C_BUS);
        repeat (16) @(negedge clk);
        chk(acts == 1 && wev === 1'b1, "no restart at top");
        send(C_SRD);
        chk(cme === 1'b1, "single read in continuous");
        t = cfg;
        t.samp_count = 11'h002;
        bad_cfg(t);
        send(C_ABT);
        repeat (3) @(negedge clk);
        chk(idl === 1'b0, "continuous abort idled");
        cfg.cont_init = 1'b0;
        send(C_ABT);
        chk(idl === 1'b1, "one shot abort not idle");
        stop_test();
    end
endmodule : tsrb_tb_top
`default_nettype wire
